//--- core/gauge_cmd_pkg.sv
// shared constants for the gauge host command decoder
// assumes a byte-wide transport front end that delivers addressed reads and writes
// Notes on behaviour
// R1 - each word command moves two bytes over two consecutive transactions; charge and margin are single bytes
// R2 - command codes map to control word, charge byte, margin byte, then word pairs
// R3 - control word accepts writes in any access state; all others read-only
// R4 - host writes a subcommand into control word, then reads result back there
// R5 - subcommands 0x0020 and up run only while unsealed; lower ones always
// R6 - subcommand 0x0000 returns the packed control status word
// R7 - identity, firmware, hardware, chemistry and stored-data versions are reported
// R8 - subcommand 0x0005 returns the count of resets undergone
// R9 - subcommand 0x0007 returns previous subcommand, limited below 0x0020
// R10 - subcommand 0x0009 runs board calibration with busy bit set meanwhile
// R11 - 0x000A runs counter calibration with busy bit; 0x000B stores the offset
// R12 - 0x0010 sets deep-sleep bit; deep sleep entered once normal sleep seen
// R13 - first message in deep sleep is lost or stretched while oscillator restarts
// R14 - any communication in deep sleep returns to sleep and clears the bit
// R15 - 0x0017 sums chemistry data, masks top bit, top bit flags mismatch
// R16 - 0x0020 moves access state from unsealed to lock_access_cmd
// R17 - 0x0021 starts gauging, sets learning bit 2, voltage-fit and sticky capacity bits
// R18 - 0x002D toggles calibration permission; 0x0081 enters, 0x0080 leaves
// R19 - 0x0041 performs a full reset only while unsealed
// R20 - 0x0082 reports counter offset while in calibration mode
// R21 - error margin 1..100: 100 on reset, 1 both, 3 capacity, 5 resistance
// R22 - condition bit sets above margin limit and clears only back below it
// R23 - reported values keep fixed encodings, passed through unchanged
// R24 - lower command code reads the low byte, higher code the high byte
package gauge_cmd_pkg;
    localparam logic [6:0] CMD_CONTROL = 7'h00;
    localparam logic [6:0] CMD_CHARGE = 7'h02;
    localparam logic [6:0] CMD_MARGIN = 7'h03;
    localparam logic [6:0] CMD_REMAIN = 7'h04;
    localparam logic [6:0] CMD_FULLCAP = 7'h06;
    localparam logic [6:0] CMD_PACK_VOLTAGE = 7'h08;
    localparam logic [6:0] CMD_MEANCUR = 7'h0A;
    localparam logic [6:0] CMD_TEMP = 7'h0C;
    localparam logic [6:0] CMD_STATUS = 7'h0E;
    localparam logic [6:0] CMD_INSTCUR = 7'h10;
    localparam logic [6:0] CMD_STATUS2 = 7'h12;

    localparam logic [15:0] SUB_STATUS = 16'h0000;
    localparam logic [15:0] SUB_IDENT = 16'h0001;
    localparam logic [15:0] SUB_FWREV = 16'h0002;
    localparam logic [15:0] SUB_HWREV = 16'h0003;
    localparam logic [15:0] SUB_RESETS = 16'h0005;
    localparam logic [15:0] SUB_PREV = 16'h0007;
    localparam logic [15:0] SUB_CHEM = 16'h0008;
    localparam logic [15:0] SUB_BOARDCAL = 16'h0009;
    localparam logic [15:0] SUB_CCCAL = 16'h000A;
    localparam logic [15:0] SUB_CCSAVE = 16'h000B;
    localparam logic [15:0] SUB_DFREV = 16'h000C;
    localparam logic [15:0] SUB_DEEPSLEEP = 16'h0010;
    localparam logic [15:0] SUB_CHKSUM = 16'h0017;
    localparam logic [15:0] SUB_SEAL = 16'h0020;
    localparam logic [15:0] SUB_GAUGE = 16'h0021;
    localparam logic [15:0] SUB_CALTOG = 16'h002D;
    localparam logic [15:0] SUB_RESET = 16'h0041;
    localparam logic [15:0] SUB_EXITCAL = 16'h0080;
    localparam logic [15:0] SUB_ENTERCAL = 16'h0081;
    localparam logic [15:0] SUB_OFFCAL = 16'h0082;
    localparam logic [15:0] SUB_LOCKED_MIN = 16'h0020;
    localparam logic [15:0] PREV_LIMIT = 16'h0020;

    // control status word and learning byte bit positions
    localparam int BIT_FAS = 14;
    localparam int BIT_SS = 13;
    localparam int BIT_CAL_ACTIVE_BIT = 12;
    localparam int BIT_CCA = 11;
    localparam int BIT_BCA = 10;
    localparam int BIT_CSV = 9;
    localparam int BIT_DEEP = 5;
    localparam int BIT_SLEEP = 4;
    localparam int BIT_CONSTANT_POWER_BIT = 3;
    localparam int BIT_RUPDIS = 2;
    localparam int BIT_VOK = 1;
    localparam int BIT_QEN = 0;
    localparam int BIT_LEARN_GAUGE = 2;
    localparam int BIT_COND = 4;

    localparam logic [7:0] MARGIN_RESET = 8'h64;
    localparam logic [7:0] MARGIN_BOTH = 8'h01;
    localparam logic [7:0] MARGIN_CAP = 8'h03;
    localparam logic [7:0] MARGIN_RES = 8'h05;
    localparam logic [15:0] SUM_MASK = 16'h7FFF;
    localparam logic [15:0] SUM_FAIL = 16'h8000;

    // oscillator restart stretch, ms
    localparam int STRETCH_MS = 8;
    localparam int CLK_MHZ = 100;
    localparam int STRETCH_CYC = STRETCH_MS * 1000 * CLK_MHZ;
    localparam int BOARDCAL_CYC = 64;
    localparam int CCCAL_CYC = 64;
endpackage

//--- core/gauge_host_command_decoder.sv
// host command decoder: standard command map, control subcommands, status word
// assumes the transport front end sends single-cycle byte strobes in mclk domain
`timescale 1ns/1ns
module gauge_host_command_decoder
    import gauge_cmd_pkg::*;
#(
    parameter int STRETCH_CYCLES = STRETCH_CYC,
    parameter int CHEM_WORDS = 8,
    // identity value is arbitrary
    parameter logic [15:0] IDENT_CODE = 16'h0A5A,
    parameter logic [15:0] FW_REV = 16'h0001,
    parameter logic [15:0] HW_REV = 16'h0001,
    parameter logic [15:0] CHEM_CODE = 16'h0001,
    parameter logic [15:0] DF_REV = 16'h0001
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // byte access from the transport
    input wire logic accWrite,
    input wire logic accRead,
    input wire logic [6:0] accCode,
    input wire logic [7:0] accWdata,
    output logic [7:0] accRdata,
    output logic accRvalid,
    output logic accStall,
    output logic accDrop,
    // gauging core values
    input wire logic [7:0] chargeIn,
    input wire logic [15:0] remainIn,
    input wire logic [15:0] fullCapIn,
    input wire logic [15:0] voltIn,
    input wire logic [15:0] meanCurIn,
    input wire logic [15:0] tempIn,
    input wire logic [15:0] statusIn,
    input wire logic [15:0] instCurIn,
    input wire logic [15:0] status2In,
    input wire logic [15:0] ccOffsetIn,
    input wire logic [15:0] chemSumStored,
    input wire logic [15:0] chemWord,
    input wire logic [7:0] marginLimit,
    // update and power events from the gauging core
    input wire logic updCap,
    input wire logic updRes,
    input wire logic voltUnfit,
    input wire logic sleepEntered,
    input wire logic sleepLeft,
    input wire logic oneWireMode,
    input wire logic calDone,
    // control outputs
    output logic [15:0] control_state_word,
    output logic [7:0] learning_state_byte,
    output logic condition_bit,
    output logic gaugingRun,
    output logic boardOffsetStore,
    output logic counterOffsetStore,
    output logic fullReset,
    output logic oscStopped,
    output logic [$clog2(CHEM_WORDS)-1:0] chemAddr
);
    initial begin
        if (CHEM_WORDS < 2 || STRETCH_CYCLES < 1) begin
            $error("bad parameter");
        end
    end

    logic lock_access_cmd, calAllow, calActive, ccBusy, bcBusy, checksum_good_bit, deep, sleep, voltage_fit_bit, capacity_update_on_bit;
    logic [15:0] ctrlWord, prevCmd, resets, sum;
    logic [7:0] margin, cmdLow;
    logic [6:0] bcCnt;
    logic [$clog2(CHEM_WORDS):0] sumIdx;
    logic summing, stretching;
    logic [31:0] stretchCnt;

    // a byte into code 0x01 completes the subcommand word
    wire ctrlWr = accWrite && accCode[6:1] == CMD_CONTROL[6:1]; // see R3
    wire subGo = ctrlWr && accCode[0] && !deep && !stretching; // see R1
    wire [15:0] sub = {accWdata, cmdLow}; // see R4 R24
    wire locked = sub >= SUB_LOCKED_MIN; // see R5
    wire allowed = !locked || !lock_access_cmd; // see R5
    wire doSub = subGo && allowed;
    wire anyAcc = accWrite || accRead;
    wire deepHit = anyAcc && deep; // see R14

    wire [15:0] statusWord = {1'b0, lock_access_cmd, lock_access_cmd, calActive, ccBusy, bcBusy, checksum_good_bit, 1'b0,
                              2'b00, deep, sleep, 1'b0, 1'b0, voltage_fit_bit, capacity_update_on_bit}; // see R6
    assign control_state_word = statusWord;
    assign condition_bit = learning_state_byte[BIT_COND];

    function automatic logic [15:0] pick(input logic [6:0] c, input logic [15:0] ctl);
        case ({c[6:1], 1'b0})
            CMD_CONTROL: pick = ctl;
            CMD_REMAIN: pick = remainIn; // see R23
            CMD_FULLCAP: pick = fullCapIn;
            CMD_PACK_VOLTAGE: pick = voltIn;
            CMD_MEANCUR: pick = meanCurIn;
            CMD_TEMP: pick = tempIn;
            CMD_STATUS: pick = statusIn;
            CMD_INSTCUR: pick = instCurIn;
            CMD_STATUS2: pick = status2In;
            default: pick = 16'h0000;
        endcase
    endfunction

    wire [15:0] wordSel = pick(accCode, ctrlWord);
    wire [7:0] byteSel = accCode == CMD_CHARGE ? chargeIn :
                         accCode == CMD_MARGIN ? margin :
                         accCode[0] ? wordSel[15:8] : wordSel[7:0]; // see R2 R24

    // stretch on two-wire, silent drop on one-wire
    assign accStall = stretching; // see R13
    assign accDrop = deepHit && oneWireMode; // see R13
    assign oscStopped = deep && sleep; // see R12
    assign chemAddr = sumIdx[$clog2(CHEM_WORDS)-1:0];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            accRdata <= 8'h00;
            accRvalid <= 1'b0;
        end else begin
            accRvalid <= accRead && !deep && !stretching;
            if (accRead) begin
                accRdata <= byteSel;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stretching <= 1'b0;
            stretchCnt <= 32'h00000000;
        end else if (deepHit && !oneWireMode) begin
            stretching <= 1'b1;
            stretchCnt <= 32'(STRETCH_CYCLES - 1);
        end else if (stretching) begin
            if (stretchCnt == 32'h00000000) begin
                stretching <= 1'b0;
            end else begin
                stretchCnt <= stretchCnt - 32'h00000001;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmdLow <= 8'h00;
            ctrlWord <= 16'h0000;
            prevCmd <= 16'h0000;
            lock_access_cmd <= 1'b0;
            calAllow <= 1'b0;
            calActive <= 1'b0;
            gaugingRun <= 1'b0;
        end else begin
            // a low byte that only wakes the device must not become half a subcommand
            if (ctrlWr && !accCode[0] && !deep && !stretching) begin
                cmdLow <= accWdata;
            end
            if (doSub) begin
                if (sub < PREV_LIMIT) begin
                    prevCmd <= sub; // see R9
                end
                case (sub)
                    SUB_STATUS: ctrlWord <= statusWord;
                    SUB_IDENT: ctrlWord <= IDENT_CODE; // see R7
                    SUB_FWREV: ctrlWord <= FW_REV;
                    SUB_HWREV: ctrlWord <= HW_REV;
                    SUB_CHEM: ctrlWord <= CHEM_CODE;
                    SUB_DFREV: ctrlWord <= DF_REV;
                    SUB_RESETS: ctrlWord <= resets; // see R8
                    SUB_PREV: ctrlWord <= prevCmd; // see R9
                    SUB_SEAL: lock_access_cmd <= 1'b1; // see R16
                    SUB_GAUGE: gaugingRun <= 1'b1; // see R17
                    SUB_CALTOG: calAllow <= !calAllow; // see R18
                    SUB_ENTERCAL: calActive <= calAllow ? 1'b1 : calActive;
                    SUB_EXITCAL: calActive <= calAllow ? 1'b0 : calActive;
                    SUB_OFFCAL: ctrlWord <= calActive ? ccOffsetIn : ctrlWord; // see R20
                    default: ctrlWord <= ctrlWord;
                endcase
            end else if (summing && sumIdx == CHEM_WORDS[$clog2(CHEM_WORDS):0]) begin
                ctrlWord <= ((sum & SUM_MASK) == (chemSumStored & SUM_MASK)) ? (sum & SUM_MASK)
                            : ((sum & SUM_MASK) | SUM_FAIL); // see R15
            end
        end
    end

    // full reset pulse goes to the rest of the device; the reset counter survives it
    assign fullReset = doSub && sub == SUB_RESET; // see R19

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            resets <= 16'h0000;
        end else if (fullReset) begin
            resets <= resets + 16'h0001; // see R8
        end
    end

    // checksum walks the chemistry store one word per cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            summing <= 1'b0;
            sumIdx <= '0;
            sum <= 16'h0000;
            checksum_good_bit <= 1'b0;
        end else if (doSub && sub == SUB_CHKSUM) begin
            summing <= 1'b1;
            sumIdx <= '0;
            sum <= 16'h0000;
        end else if (summing) begin
            if (sumIdx == CHEM_WORDS[$clog2(CHEM_WORDS):0]) begin
                summing <= 1'b0;
                checksum_good_bit <= (sum & SUM_MASK) == (chemSumStored & SUM_MASK);
            end else begin
                sum <= sum + chemWord; // see R15
                sumIdx <= sumIdx + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bcBusy <= 1'b0;
            ccBusy <= 1'b0;
            bcCnt <= 7'h00;
            boardOffsetStore <= 1'b0;
            counterOffsetStore <= 1'b0;
        end else begin
            boardOffsetStore <= 1'b0;
            counterOffsetStore <= doSub && sub == SUB_CCSAVE; // see R11
            if (doSub && sub == SUB_BOARDCAL) begin
                bcBusy <= 1'b1; // see R10
                bcCnt <= 7'(BOARDCAL_CYC - 1);
            end else if (bcBusy) begin
                if (bcCnt == 7'h00) begin
                    bcBusy <= 1'b0;
                    boardOffsetStore <= 1'b1;
                end else begin
                    bcCnt <= bcCnt - 7'h01;
                end
            end
            if (doSub && sub == SUB_CCCAL) begin
                ccBusy <= 1'b1; // see R11
            end else if (calDone) begin
                ccBusy <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            deep <= 1'b0;
            sleep <= 1'b0;
        end else begin
            if (sleepEntered) begin
                sleep <= 1'b1;
            end else if (sleepLeft) begin
                sleep <= 1'b0;
            end
            if (doSub && sub == SUB_DEEPSLEEP) begin
                deep <= 1'b1; // see R12
            end else if (deepHit) begin
                deep <= 1'b0; // see R14
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            voltage_fit_bit <= 1'b0;
            capacity_update_on_bit <= 1'b0;
            learning_state_byte <= 8'h00;
            margin <= MARGIN_RESET;
        end else begin
            if (doSub && sub == SUB_GAUGE) begin
                voltage_fit_bit <= 1'b1; // see R17
                capacity_update_on_bit <= 1'b1;
                learning_state_byte[BIT_LEARN_GAUGE] <= 1'b1;
            end else if (voltUnfit) begin
                voltage_fit_bit <= 1'b0;
            end
            if (fullReset) begin
                margin <= MARGIN_RESET; // see R21
            end else if (updCap && updRes) begin
                margin <= MARGIN_BOTH;
            end else if (updCap) begin
                margin <= MARGIN_CAP;
            end else if (updRes) begin
                margin <= MARGIN_RES;
            end
            if (margin > marginLimit) begin
                learning_state_byte[BIT_COND] <= 1'b1; // see R22
            end else if (margin < marginLimit) begin
                learning_state_byte[BIT_COND] <= 1'b0;
            end
        end
    end

    a_seal_locks: assert property (@(posedge mclk) disable iff (!nrst)
        lock_access_cmd |=> lock_access_cmd) else $error("lock_access_cmd state left"); // see R16
    a_lock_access_cmd_gauge_blocked: assert property (@(posedge mclk) disable iff (!nrst)
        (subGo && lock_access_cmd && sub == SUB_GAUGE && !gaugingRun) |=> !gaugingRun)
        else $error("gauging started while lock_access_cmd"); // see R5
    a_qen_sticky: assert property (@(posedge mclk) disable iff (!nrst)
        capacity_update_on_bit |=> capacity_update_on_bit) else $error("capacity update bit cleared"); // see R17
    a_prev_limit: assert property (@(posedge mclk) disable iff (!nrst)
        prevCmd < PREV_LIMIT) else $error("previous subcommand over limit"); // see R9
    a_margin_range: assert property (@(posedge mclk) disable iff (!nrst)
        margin >= MARGIN_BOTH && margin <= MARGIN_RESET) else $error("margin out of range"); // see R21
    a_reset_margin: assert property (@(posedge mclk) disable iff (!nrst)
        fullReset |=> margin == MARGIN_RESET) else $error("margin not 100 after reset"); // see R21
    a_deep_clear: assert property (@(posedge mclk) disable iff (!nrst)
        (deepHit && !(doSub && sub == SUB_DEEPSLEEP)) |=> !deep) else $error("deep sleep kept"); // see R14
    a_board_busy: assert property (@(posedge mclk) disable iff (!nrst)
        (doSub && sub == SUB_BOARDCAL) |=> bcBusy [*8]) else $error("board cal busy dropped"); // see R10
    a_ident_read: assert property (@(posedge mclk) disable iff (!nrst)
        (doSub && sub == SUB_IDENT) |=> ctrlWord == IDENT_CODE) else $error("identity not loaded"); // see R7
    a_cond_set: assert property (@(posedge mclk) disable iff (!nrst)
        (margin > marginLimit) |=> condition_bit) else $error("condition bit not set"); // see R22
endmodule

//--- verification/host_model.sv
// host model: issues byte reads, writes and subcommands to the decoder
// assumes its tasks are entered just after a falling edge of mclk
`timescale 1ns/1ns
module host_model (
    // clock
    input wire logic mclk,
    // answers from the decoder
    input wire logic [7:0] accRdata,
    input wire logic accRvalid,
    input wire logic accStall,
    // requests
    output logic accWrite,
    output logic accRead,
    output logic [6:0] accCode,
    output logic [7:0] accWdata
);
    initial begin
        accWrite = 1'b0;
        accRead = 1'b0;
        accCode = 7'h7F;
        accWdata = 8'hFF;
    end

    // a request made during the stretch is lost, so sit the stretch out first
    task automatic hold_off();
        for (int n = 0; n < 1000 && accStall === 1'b1; n++) begin
            @(negedge mclk);
        end
    endtask

    // released lines show inverted values so a stale byte never matches
    task automatic release_bus();
        accWrite = 1'b0;
        accRead = 1'b0;
        accCode = ~accCode;
        accWdata = ~accWdata;
        @(negedge mclk);
    endtask

    task automatic put(input logic [6:0] code, input logic [7:0] data);
        hold_off();
        accCode = code;
        accWdata = data;
        accWrite = 1'b1;
        @(negedge mclk);
        release_bus();
    endtask

    task automatic get(input logic [6:0] code, output logic [7:0] data);
        hold_off();
        accCode = code;
        accRead = 1'b1;
        @(negedge mclk);
        data = (accRvalid === 1'b1) ? accRdata : 'x;
        release_bus();
    endtask

    task automatic rdw(input logic [6:0] code, output logic [15:0] word);
        logic [7:0] lo, hi;
        get(code, lo);
        get(code + 7'h01, hi);
        word = {hi, lo};
    endtask

    // low byte then high byte back to back; the high byte runs the subcommand
    task automatic sub(input logic [15:0] code);
        hold_off();
        accWrite = 1'b1;
        accCode = 7'h00;
        accWdata = code[7:0];
        @(negedge mclk);
        accCode = 7'h01;
        accWdata = code[15:8];
        @(negedge mclk);
        release_bus();
    endtask
endmodule

//--- verification/tb_top.sv
// bench for the gauge command decoder, one task per scenario
// assumes host_model makes every byte request; stretch shortened to 10 cycles
`timescale 1ns/1ns
module tb_top;
    import gauge_cmd_pkg::*;
    localparam logic [15:0] PV [8] = '{16'h1234, 16'h2345, 16'h3456, 16'hFEDC, 16'h0BB8, 16'h4567, 16'h8001, 16'h5678};
    // identity and version values are arbitrary
    localparam logic [15:0] ID [5] = '{16'h3C5A, 16'h0102, 16'h0203, 16'h0304, 16'h0405};
    localparam logic [15:0] SUBS [5] = '{SUB_IDENT, SUB_FWREV, SUB_HWREV, SUB_CHEM, SUB_DFREV};
    localparam logic [5:0] MEV [3] = '{6'h01, 6'h02, 6'h03};
    localparam logic [7:0] MEXP [3] = '{MARGIN_CAP, MARGIN_RES, MARGIN_BOTH};
    localparam logic [15:0] LK [4] = '{SUB_GAUGE, SUB_CALTOG, SUB_ENTERCAL, SUB_RESET};
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic oneWireMode = 1'b0;
    logic accWrite, accRead, accRvalid, accStall, accDrop, condition_bit, gaugingRun;
    logic boardOffsetStore, counterOffsetStore, fullReset, oscStopped;
    logic [6:0] accCode;
    logic [7:0] accWdata, accRdata, learning_state_byte, b;
    logic [7:0] marginLimit = 8'h04;
    logic [15:0] chemSumStored = 16'h001C;
    logic [15:0] chemWord, control_state_word, w;
    logic [5:0] evt = 6'h00;
    logic [2:0] chemAddr;
    int num_errors = 0;
    int cmp_count = 0;
    int nRst = 0, nBrd = 0, nCc = 0, nStall = 0, nDrop = 0;

    always #5 mclk = ~mclk;
    // eight words summing to 0x801C, so the masked sum is 0x001C
    assign chemWord = 16'h1000 + {13'h0, chemAddr};

    always @(posedge mclk) begin
        if (fullReset === 1'b1) nRst++;
        if (boardOffsetStore === 1'b1) nBrd++;
        if (counterOffsetStore === 1'b1) nCc++;
        if (accStall === 1'b1) nStall++;
        if (accDrop === 1'b1) nDrop++;
    end

    host_model i_host (.mclk(mclk), .accRdata(accRdata), .accRvalid(accRvalid), .accStall(accStall),
        .accWrite(accWrite), .accRead(accRead), .accCode(accCode), .accWdata(accWdata));

    gauge_host_command_decoder #(.STRETCH_CYCLES(10), .CHEM_WORDS(8), .IDENT_CODE(ID[0]), .FW_REV(ID[1]),
        .HW_REV(ID[2]), .CHEM_CODE(ID[3]), .DF_REV(ID[4])) i_dut (
        .mclk(mclk), .nrst(nrst), .accWrite(accWrite), .accRead(accRead), .accCode(accCode),
        .accWdata(accWdata), .accRdata(accRdata), .accRvalid(accRvalid), .accStall(accStall),
        .accDrop(accDrop), .chargeIn(8'h37), .remainIn(PV[0]), .fullCapIn(PV[1]), .voltIn(PV[2]),
        .meanCurIn(PV[3]), .tempIn(PV[4]), .statusIn(PV[5]), .instCurIn(PV[6]), .status2In(PV[7]),
        .ccOffsetIn(16'hFFF3), .chemSumStored(chemSumStored), .chemWord(chemWord),
        .marginLimit(marginLimit), .updCap(evt[0]), .updRes(evt[1]), .voltUnfit(evt[2]),
        .sleepEntered(evt[3]), .sleepLeft(evt[4]), .oneWireMode(oneWireMode), .calDone(evt[5]),
        .control_state_word(control_state_word), .learning_state_byte(learning_state_byte),
        .condition_bit(condition_bit), .gaugingRun(gaugingRun), .boardOffsetStore(boardOffsetStore),
        .counterOffsetStore(counterOffsetStore), .fullReset(fullReset), .oscStopped(oscStopped),
        .chemAddr(chemAddr));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        @(negedge mclk);
    endtask

    // evt bits: capacity, resistance, voltage unfit, sleep in, sleep out, cal done
    task automatic pulse(input logic [5:0] m);
        evt = m;
        @(negedge mclk);
        evt = 6'h00;
        repeat (3) @(negedge mclk);
    endtask

    task automatic subw(input logic [15:0] s, output logic [15:0] r);
        i_host.sub(s);
        i_host.rdw(CMD_CONTROL, r);
    endtask

    task automatic t_ident();
        do_reset();
        foreach (ID[i]) begin
            subw(SUBS[i], w);
            chk(w, ID[i]);
        end
        subw(SUB_PREV, w);
        chk(w, SUB_DFREV);
        $display("test ident done");
    endtask

    task automatic t_map();
        do_reset();
        i_host.get(CMD_CHARGE, b);
        chk({8'h00, b}, 16'h0037);
        i_host.put(CMD_REMAIN, 8'hAA);
        foreach (PV[i]) begin
            i_host.rdw(CMD_REMAIN + 7'(2 * i), w);
            chk(w, PV[i]);
        end
        $display("test map done");
    endtask

    task automatic t_margin();
        int n0;
        do_reset();
        i_host.get(CMD_MARGIN, b);
        chk({8'h00, b}, {8'h00, MARGIN_RESET});
        chk({15'h0, condition_bit}, 16'h0001);
        foreach (MEV[i]) begin
            pulse(MEV[i]);
            i_host.get(CMD_MARGIN, b);
            chk({8'h00, b}, {8'h00, MEXP[i]});
            chk({15'h0, learning_state_byte[BIT_COND]}, 16'(i == 1));
        end
        n0 = nRst;
        i_host.sub(SUB_RESET);
        chk(16'(nRst - n0), 16'h0001);
        subw(SUB_RESETS, w);
        chk(w, 16'h0001);
        i_host.get(CMD_MARGIN, b);
        chk({8'h00, b}, {8'h00, MARGIN_RESET});
        $display("test margin done");
    endtask

    task automatic t_gauge();
        do_reset();
        subw(SUB_STATUS, w);
        chk(w, 16'h0000);
        i_host.sub(SUB_GAUGE);
        chk(control_state_word, 16'h0003);
        chk({15'h0, learning_state_byte[BIT_LEARN_GAUGE] & gaugingRun}, 16'h0001);
        pulse(6'h04);
        subw(SUB_STATUS, w);
        chk(w, 16'h0001);
        $display("test gauge done");
    endtask

    task automatic t_cal();
        do_reset();
        i_host.sub(SUB_ENTERCAL);
        chk({15'h0, control_state_word[BIT_CAL_ACTIVE_BIT]}, 16'h0000);
        i_host.sub(SUB_CALTOG);
        i_host.sub(SUB_ENTERCAL);
        chk({15'h0, control_state_word[BIT_CAL_ACTIVE_BIT]}, 16'h0001);
        subw(SUB_OFFCAL, w);
        chk(w, 16'hFFF3);
        i_host.sub(SUB_EXITCAL);
        chk({15'h0, control_state_word[BIT_CAL_ACTIVE_BIT]}, 16'h0000);
        i_host.sub(SUB_BOARDCAL);
        chk({15'h0, control_state_word[BIT_BCA]}, 16'h0001);
        repeat (70) @(negedge mclk);
        chk({15'h0, control_state_word[BIT_BCA]}, 16'h0000);
        chk(16'(nBrd), 16'h0001);
        i_host.sub(SUB_CCCAL);
        chk({15'h0, control_state_word[BIT_CCA]}, 16'h0001);
        pulse(6'h20);
        chk({15'h0, control_state_word[BIT_CCA]}, 16'h0000);
        i_host.sub(SUB_CCSAVE);
        chk(16'(nCc), 16'h0001);
        $display("test cal done");
    endtask

    task automatic t_chksum();
        do_reset();
        for (int i = 0; i < 2; i++) begin
            chemSumStored = 16'h001C + 16'(i);
            i_host.sub(SUB_CHKSUM);
            repeat (12) @(negedge mclk);
            i_host.rdw(CMD_CONTROL, w);
            chk({15'h0, w[15]}, 16'(i));
            chk({15'h0, control_state_word[BIT_CSV]}, 16'(1 - i));
        end
        $display("test chksum done");
    endtask

    task automatic t_seal();
        int n0;
        do_reset();
        n0 = nRst;
        i_host.sub(SUB_SEAL);
        chk(control_state_word, 16'h6000);
        foreach (LK[i]) i_host.sub(LK[i]);
        chk(control_state_word, 16'h6000);
        chk({15'h0, gaugingRun}, 16'h0000);
        chk(16'(nRst - n0), 16'h0000);
        subw(SUB_IDENT, w);
        chk(w, ID[0]);
        $display("test seal done");
    endtask

    task automatic t_deep();
        int s0, d0;
        do_reset();
        i_host.sub(SUB_DEEPSLEEP);
        chk(control_state_word, 16'h0020);
        pulse(6'h08);
        chk({15'h0, oscStopped}, 16'h0001);
        s0 = nStall;
        // this first request only restarts the oscillator
        i_host.put(CMD_CONTROL, 8'h01);
        repeat (15) @(negedge mclk);
        chk(16'(nStall - s0), 16'h000A);
        chk(control_state_word, 16'h0010);
        chk({15'h0, oscStopped}, 16'h0000);
        oneWireMode = 1'b1;
        i_host.sub(SUB_DEEPSLEEP);
        d0 = nDrop;
        i_host.get(CMD_CHARGE, b);
        chk(16'(nDrop - d0), 16'h0001);
        chk(control_state_word, 16'h0010);
        oneWireMode = 1'b0;
        $display("test deep done");
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        t_ident();
        t_map();
        t_margin();
        t_gauge();
        t_cal();
        t_chksum();
        t_seal();
        t_deep();
        end_of_test();
    end

    // the tests need about 410 cycles; the limit of 20000 cycles allows about fifty times that
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule
